// *** inc/rst_ctl_pkg.sv ***
// constants and carrier types for the software reset and general configuration registers
// assumes an upstream serial control slave that turns bus transfers into single-cycle register strobes
package rst_ctl_pkg;
  // register offsets
  localparam logic [7:0] ofs_software_reset_control = 8'h01;
  localparam logic [7:0] ofs_general_configuration  = 8'h03;
  // reset control field positions
  localparam int pos_media_input_reset  = 4;
  localparam int pos_full_digital_reset = 1;
  localparam int pos_logic_only_reset   = 0;
  localparam logic [7:0] rst_ctl_mask   = 8'h13; // implemented bits 4,1,0
  localparam logic [7:0] rst_ctl_reset  = 8'h00;
  // general configuration fields
  localparam int pos_crc_check_enable   = 7;
  localparam logic [7:0] gen_cfg_reset  = 8'hd2;
  localparam logic [7:0] gen_cfg_wmask  = 8'hba; // writable bits 7,5,4,3,1
  localparam logic [7:0] gen_cfg_fixed  = 8'h40; // bit 6 holds its default
  // register access strobe from the serial control slave
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;
  // reset pulses handed to the rest of the digital core
  typedef struct packed {
    logic media_input;
    logic full_digital;
    logic logic_only;
    logic strap_reload;
    logic default_restore;
  } reset_pulse_s;
endpackage

// *** tb/reset_control_regs_tb.sv ***
// self-checking bench for the software reset control and general configuration registers
// assumes the register port takes one-cycle strobes on rising mclk and answers one cycle later
`timescale 1ns/1ps
module reset_control_regs_tb;
  import rst_ctl_pkg::*;
  typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [4:0] pulse; logic [7:0] gen;} row_s;
  logic         mclk        = 1'b0;
  logic         srst        = 1'b1;
  logic         io_3v3_mode = 1'b1;
  reg_req_s     reg_req     = '0;
  logic [7:0]   reg_rdata;
  logic [7:0]   gen_config;
  logic         crc_check_enable;
  reset_pulse_s reset_pulse;
  int           err_total   = 0;
  int           num_checks  = 0;
  int           cycles      = 0;
  // writes with the pulses and the 0x03 value each should leave behind
  row_s rows [6] = '{'{8'h01, 8'h10, 5'h10, 8'hd2}, '{8'h01, 8'h01, 5'h07, 8'hd2}, '{8'h01, 8'hec, 5'h00, 8'hd2},
                     '{8'h03, 8'h00, 5'h00, 8'h40}, '{8'h03, 8'hff, 5'h00, 8'hfa}, '{8'h05, 8'hff, 5'h00, 8'hfa}};
  // clock and hang guard
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      report_and_stop();
    end
  end
  reset_control_regs dut (.mclk(mclk), .srst(srst), .io_3v3_mode(io_3v3_mode), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reset_pulse(reset_pulse), .crc_check_enable(crc_check_enable), .gen_config(gen_config));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one strobe, launched at a falling edge and dropped on the edge that takes it; returns at the next falling edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    reg_req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge mclk);
    reg_req <= '0;
    @(negedge mclk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge mclk);
    srst = 1'b0;
    chk("gen_config", 8'hd2, gen_config);
    chk("crc_check_enable", 8'h01, {7'h0, crc_check_enable});
    chk("pulses", 8'h00, {3'h0, reset_pulse});
    xfer(1'b0, 8'h01, 8'h00);
    chk("reset control read", 8'h00, reg_rdata);
    $display("reset values done");
    @(negedge mclk); // the mode synchroniser refills for two edges after reset
    foreach (rows[i]) begin
      xfer(1'b1, rows[i].addr, rows[i].wdata);
      chk("pulses", {3'h0, rows[i].pulse}, {3'h0, reset_pulse});
      xfer(1'b0, 8'h03, 8'h00);
      chk("pulses cleared", 8'h00, {3'h0, reset_pulse});
      chk("general config read", rows[i].gen, reg_rdata);
      chk("crc_check_enable", {7'h0, rows[i].gen[7]}, {7'h0, crc_check_enable});
    end
    xfer(1'b0, 8'h05, 8'h00);
    chk("unmapped read", 8'h00, reg_rdata);
    $display("register table done");
    // full reset restores 0x03 one cycle after its pulse
    xfer(1'b1, 8'h03, 8'h00);
    xfer(1'b1, 8'h01, 8'h02);
    chk("full reset pulse", 8'h08, {3'h0, reset_pulse});
    chk("gen_config before restore", 8'h40, gen_config);
    @(negedge mclk);
    chk("gen_config after full reset", 8'hd2, gen_config);
    // software then sets the bridge control restore bit, which lives outside this block
    xfer(1'b1, 8'h4f, 8'h02);
    chk("gen_config after bridge control write", 8'hd2, gen_config);
    $display("full reset done");
    // reset writes ignored away from 3.3 V
    io_3v3_mode = 1'b0;
    repeat (3) @(negedge mclk);
    xfer(1'b1, 8'h01, 8'h13);
    chk("pulses at low io", 8'h00, {3'h0, reset_pulse});
    io_3v3_mode = 1'b1;
    repeat (3) @(negedge mclk);
    xfer(1'b1, 8'h01, 8'h13);
    chk("pulses at 3v3", 8'h1f, {3'h0, reset_pulse});
    $display("io mode done");
    // a 0x03 write in the cycle of the full reset pulse loses to the restore
    xfer(1'b1, 8'h03, 8'h00);
    chk("gen_config under full reset", 8'hd2, gen_config);
    $display("full reset overlap done");
    // a mid-run reset returns the registers to their defaults
    xfer(1'b1, 8'h03, 8'h00);
    chk("gen_config before srst", 8'h40, gen_config);
    srst = 1'b1;
    repeat (3) @(negedge mclk);
    srst = 1'b0;
    chk("gen_config after srst", 8'hd2, gen_config);
    chk("crc after srst", 8'h01, {7'h0, crc_check_enable});
    chk("pulses after srst", 8'h00, {3'h0, reset_pulse});
    $display("mid-run reset done");
    report_and_stop();
  end
endmodule

// *** verilog/reset_control_regs.sv ***
// software reset control and general configuration registers
// assumes reg_req strobes are on mclk and last one cycle; io_3v3_mode comes from a pin
// reset control writes are ignored for two edges after srst while the mode synchroniser refills
`timescale 1ns/1ps

module reset_control_regs (
  input  wire logic                      mclk,
  input  wire logic                      srst,
  input  wire logic                      io_3v3_mode,
  input  wire rst_ctl_pkg::reg_req_s     reg_req,
  output logic [7:0]                     reg_rdata,
  output rst_ctl_pkg::reset_pulse_s      reset_pulse,
  output logic                           crc_check_enable,
  output logic [7:0]                     gen_config
);
  import rst_ctl_pkg::*;

  // synchroniser stages for the io voltage mode pin
  logic       v33_meta;
  logic       v33_sync;
  // register state
  logic [7:0] rst_ctl;
  logic [7:0] gen_cfg;
  // next values of the register state and the read data
  logic [7:0] next_rst_ctl;
  logic [7:0] next_gen_cfg;
  logic [7:0] next_rdata;
  // address hits and qualified write strobes
  wire        hit_rst;
  wire        hit_cfg;
  wire        wr_rst;
  wire        wr_cfg;
  // write data with unimplemented and fixed bits already applied
  wire  [7:0] rst_written;
  wire  [7:0] cfg_written;
  // a standing full digital reset pulse, which reloads general configuration
  wire        restore_cfg;

  // read decode for both registers, unmapped offsets read zero
  function automatic logic [7:0] read_mux(input logic [7:0] a, input logic [7:0] r, input logic [7:0] g);
    read_mux = (a == ofs_software_reset_control) ? (r & rst_ctl_mask) :
               (a == ofs_general_configuration)  ? g : 8'h00;
  endfunction

  // two-stage synchroniser for the io voltage mode pin
  // both stages clear under srst, so reset control writes stay ignored for two edges after release
  always_ff @(posedge mclk) begin
    v33_meta <= srst ? 1'b0 : io_3v3_mode;
    v33_sync <= srst ? 1'b0 : v33_meta;
  end

  // address hits shared by the write decode
  assign hit_rst = (reg_req.addr == ofs_software_reset_control);
  assign hit_cfg = (reg_req.addr == ofs_general_configuration);

  // write decode; reset writes gated by the voltage mode, other io modes are not supported
  assign wr_rst = reg_req.wr && hit_rst && v33_sync;
  assign wr_cfg = reg_req.wr && hit_cfg;

  // only the implemented reset bits are kept; they live one cycle then clear themselves
  assign rst_written  = reg_req.wdata & rst_ctl_mask;
  assign next_rst_ctl = wr_rst ? rst_written : rst_ctl_reset;

  // general configuration: writable bits from the bus, bit 6 pinned high, bits 2 and 0 read zero
  assign cfg_written  = (reg_req.wdata & gen_cfg_wmask) | gen_cfg_fixed;
  // the full reset pulse outranks a write in the same cycle, so the default always lands
  assign restore_cfg  = rst_ctl[pos_full_digital_reset];
  assign next_gen_cfg = restore_cfg ? gen_cfg_reset : (wr_cfg ? cfg_written : gen_cfg);

  // read data is registered; idle cycles and unmapped offsets give zero
  assign next_rdata   = reg_req.rd ? read_mux(reg_req.addr, rst_ctl, gen_cfg) : 8'h00;

  // register state
  always_ff @(posedge mclk) begin
    if (srst) begin
      rst_ctl   <= rst_ctl_reset;
      gen_cfg   <= gen_cfg_reset;
      reg_rdata <= 8'h00;
    end else begin
      rst_ctl   <= next_rst_ctl;
      gen_cfg   <= next_gen_cfg;
      reg_rdata <= next_rdata;
    end
  end

  // reset pulses to the digital core
  assign reset_pulse.media_input     = rst_ctl[pos_media_input_reset];
  assign reset_pulse.full_digital    = rst_ctl[pos_full_digital_reset];
  assign reset_pulse.logic_only      = rst_ctl[pos_logic_only_reset];
  assign reset_pulse.strap_reload    = rst_ctl[pos_logic_only_reset];
  assign reset_pulse.default_restore = rst_ctl[pos_logic_only_reset];
  assign crc_check_enable            = gen_cfg[pos_crc_check_enable];
  assign gen_config                  = gen_cfg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  // a reset control write while the synchronised mode flag is low must leave every reset bit clear
  gated_reset_write_a: assert property (
    reg_req.wr && reg_req.addr == ofs_software_reset_control && !v33_sync |=> rst_ctl == rst_ctl_reset
  ) else $error("reset write honoured outside 3.3 V mode");

  // an honoured reset write needs the mode pin high two edges earlier, the synchroniser latency
  mode_latency_a: assert property (
    wr_rst |-> $past(io_3v3_mode, 2)
  ) else $error("reset write honoured before the mode pin was synchronised");

  // a media input reset write gives one cycle of pulse unless the next cycle writes it again
  media_pulse_a: assert property (
    wr_rst && reg_req.wdata[pos_media_input_reset] ##1 !(wr_rst && reg_req.wdata[pos_media_input_reset])
    |-> reset_pulse.media_input ##1 !reset_pulse.media_input
  ) else $error("media input reset not a one-cycle pulse");

  // a full digital reset write raises its pulse on the next cycle
  full_pulse_a: assert property (
    wr_rst && reg_req.wdata[pos_full_digital_reset] |=> reset_pulse.full_digital
  ) else $error("full digital reset write gave no pulse");

  // the full reset pulse returns general configuration to its default one cycle later
  full_restore_a: assert property (
    wr_rst && reg_req.wdata[pos_full_digital_reset] |=> ##1 gen_cfg == gen_cfg_reset
  ) else $error("full reset did not restore general configuration");

  // a general configuration write that meets the full reset pulse loses to the restore
  full_wins_a: assert property (
    restore_cfg && wr_cfg |=> gen_cfg == gen_cfg_reset
  ) else $error("write overrode the full reset restore");

  // a logic-only reset write raises its pulse on the next cycle
  logic_pulse_a: assert property (
    wr_rst && reg_req.wdata[pos_logic_only_reset] |=> reset_pulse.logic_only
  ) else $error("logic-only reset write gave no pulse");

  // a logic-only reset on its own keeps general configuration as it was
  logic_keep_a: assert property (
    wr_rst && reg_req.wdata[pos_logic_only_reset] && !reg_req.wdata[pos_full_digital_reset]
    ##1 !wr_cfg |=> $stable(gen_cfg)
  ) else $error("logic-only reset disturbed registers");

  // strapped registers reload on every logic-only reset write
  strap_reload_a: assert property (
    wr_rst && reg_req.wdata[pos_logic_only_reset] |=> reset_pulse.strap_reload
  ) else $error("strap reload missing on logic-only reset");

  // the listed registers return to their defaults on every logic-only reset write
  default_restore_a: assert property (
    wr_rst && reg_req.wdata[pos_logic_only_reset] |=> reset_pulse.default_restore
  ) else $error("default restore missing on logic-only reset");

  // no reset bit outlives its cycle unless it was written again
  self_clear_a: assert property (
    rst_ctl != rst_ctl_reset |=> rst_ctl == rst_ctl_reset || $past(wr_rst)
  ) else $error("reset bit did not clear itself");

  // without an honoured reset write every reset bit rests at zero
  pulses_quiet_a: assert property (
    !wr_rst |=> rst_ctl == rst_ctl_reset
  ) else $error("reset bit raised without a write");

  // a general configuration write sets or clears the crc checker enable
  crc_enable_a: assert property (
    wr_cfg && !restore_cfg |=> crc_check_enable == $past(reg_req.wdata[pos_crc_check_enable])
  ) else $error("crc checker enable does not follow write");

  // without a write or a restore the general configuration holds its value
  cfg_hold_a: assert property (
    !wr_cfg && !restore_cfg |=> $stable(gen_cfg)
  ) else $error("general configuration changed on its own");

  // bit 6 keeps its default and bits 2 and 0 stay clear whatever is written
  cfg_fixed_a: assert property (
    (gen_cfg & ~gen_cfg_wmask) == gen_cfg_fixed
  ) else $error("fixed general configuration bits changed");

  // reserved general configuration bits read back as zero
  reserved_zero_a: assert property (
    reg_req.rd && reg_req.addr == ofs_general_configuration |=> reg_rdata[2] == 1'b0 && reg_rdata[0] == 1'b0
  ) else $error("reserved general configuration bit reads nonzero");

  // reserved reset control bits read back as zero
  reserved_rst_a: assert property (
    reg_req.rd && reg_req.addr == ofs_software_reset_control |=> (reg_rdata & ~rst_ctl_mask) == 8'h00
  ) else $error("reserved reset control bit reads nonzero");

  // a reset control read shows the bits standing in the cycle it was taken
  rst_read_a: assert property (
    reg_req.rd && reg_req.addr == ofs_software_reset_control |=> reg_rdata == $past(rst_ctl)
  ) else $error("reset control read returned a wrong value");

  // a general configuration read returns the register as it stood when the read was taken
  cfg_read_a: assert property (
    reg_req.rd && reg_req.addr == ofs_general_configuration |=> reg_rdata == $past(gen_cfg)
  ) else $error("general configuration read returned a stale value");

  // reads of offsets outside this block return zero
  unmapped_read_a: assert property (
    reg_req.rd && reg_req.addr != ofs_software_reset_control && reg_req.addr != ofs_general_configuration
    |=> reg_rdata == 8'h00
  ) else $error("unmapped read returned nonzero data");

  // without a read the data output rests at zero
  idle_read_a: assert property (
    !reg_req.rd |=> reg_rdata == 8'h00
  ) else $error("read data not zero without a read");

  // both registers leave reset at their defaults
  reset_value_a: assert property (
    $fell(srst) |-> gen_cfg == gen_cfg_reset && rst_ctl == rst_ctl_reset
  ) else $error("wrong value after reset");

  // main scenarios: each reset kind, a blocked reset write and the crc checker switched off
  media_reset_c: cover property (wr_rst && reg_req.wdata[pos_media_input_reset]);
  full_reset_c:  cover property (wr_rst && reg_req.wdata[pos_full_digital_reset]);
  logic_reset_c: cover property (wr_rst && reg_req.wdata[pos_logic_only_reset]);
  crc_off_c:     cover property (wr_cfg ##1 !crc_check_enable);
  blocked_c:     cover property (reg_req.wr && reg_req.addr == ofs_software_reset_control && !v33_sync);
endmodule
